// *** core/ftlv_top.sv ***
/*
 * Flash timeout and low-voltage configuration registers with startup supply
 * check, constant-voltage select and flash pulse timing.
 * Assumes a two-wire bus slave outside that presents decoded single-cycle
 * register reads and writes, and an analog comparator that reports the supply
 * below the selected startup threshold.
 */
// Overview of operation
// [R1] Enable rising with low supply and shutdown clear: reduced current, fault set.
// [R2] Enable rising with low supply and shutdown set: stay off, fault set.
// [R3] Low-voltage shutdown select is read/write bit 6, reset 0.
// [R4] Constant-voltage bit clear: normal operation chosen by the mode field.
// [R5] Constant-voltage bit set: both boost outputs held at 5 V; bit resets 0.
// [R6] Host clears mode, output enable and torch enable before setting constant-voltage.
// [R7] Timer code 0h to 7Fh: 2 ms steps, 2 ms to 256 ms.
// [R8] Codes 80h and up: (code-127)*8+256 ms, up to 1280 ms.
// [R9] Flash timer register at address 5, read/write, reset 23h (72 ms).
// [R10] Startup threshold code 0 disables the check, 1-7 rising, reset 5h.
// [R11] Flash mode: output enable and mode cleared when the flash pulse ends.
// [R12] Timer starts with the flash pulse and ends it at the programmed duration.
`include "ftlv_regs.svh"
`default_nettype none

module ftlv_top #(
	parameter int CYC_PER_MS = `FTLV_CYC_PER_MS
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Register access from the two-wire bus slave.
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// Analog and fault interface.
	input wire logic i_vin_below_start,
	input wire logic i_fault_clr,
	output logic [2:0] o_start_thresh,
	output logic [2:0] o_run_thresh,
	output logic o_fault_uvlo,
	// Driver control.
	output ftlv_pkg::ftlv_mode_e o_mode,
	output logic o_sink_enable,
	output logic o_reduced_current,
	output logic o_const_v_boost_outputs,
	output logic o_flash_active
);
	import ftlv_pkg::*;

	typedef struct packed
	{
		logic [2:0] lv_run;
		logic [2:0] lv_start;
		logic lv_shdn;
		logic const_v;
		logic [7:0] timer_code;
		ftlv_mode_e mode;
		logic out_on;
		ftlv_state_e state;
		logic reduced;
		logic fault;
		logic [7:0] rdata;
	} ftlv_s;

	ftlv_s cur_ff;
	ftlv_s nxt_cur;
	logic wr_lv;
	logic wr_timer;
	logic wr_ctrl;
	logic new_out_on;
	ftlv_mode_e new_mode;
	logic out_on_rise;
	logic low_at_start;
	logic tmr_start;
	logic tmr_done;
	logic tmr_busy;

	// -----------------------------------------------------------------------
	// Address decode.
	// -----------------------------------------------------------------------
	assign wr_lv = i_reg_wr && (i_reg_addr == `FTLV_ADDR_LV_CFG);
	assign wr_timer = i_reg_wr && (i_reg_addr == `FTLV_ADDR_TIMER); // see [R9]
	assign wr_ctrl = i_reg_wr && (i_reg_addr == `FTLV_ADDR_CTRL);
	assign new_out_on = wr_ctrl ? i_reg_wdata[`FTLV_CTRL_OUTON_BIT] : cur_ff.out_on;
	assign new_mode = wr_ctrl
		? ftlv_mode_e'(i_reg_wdata[`FTLV_CTRL_MODE_MSB:`FTLV_CTRL_MODE_LSB])
		: cur_ff.mode;
	assign out_on_rise = new_out_on && !cur_ff.out_on;
	// Threshold code 0 turns the startup check off. see [R10]
	assign low_at_start = i_vin_below_start && (cur_ff.lv_start != `FTLV_THRESH_OFF);
	// The startup check and the flash timer only act in flash mode.
	assign tmr_start = out_on_rise && (new_mode == FTLV_MODE_FLASH)
		&& !(low_at_start && cur_ff.lv_shdn) && !cur_ff.const_v; // see [R12]

	ftlv_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_start(tmr_start),
		.i_stop(!new_out_on),
		.i_code(cur_ff.timer_code),
		.o_busy(tmr_busy),
		.o_done(tmr_done)
	);

	// -----------------------------------------------------------------------
	// Next-state logic.
	// -----------------------------------------------------------------------
	always_comb
	begin
		nxt_cur = cur_ff;
		if (wr_lv)
		begin
			nxt_cur.lv_run = i_reg_wdata[`FTLV_LV_RUN_MSB:`FTLV_LV_RUN_LSB];
			nxt_cur.lv_start = i_reg_wdata[`FTLV_LV_START_MSB:`FTLV_LV_START_LSB];
			nxt_cur.lv_shdn = i_reg_wdata[`FTLV_LV_SHDN_BIT]; // see [R3]
			nxt_cur.const_v = i_reg_wdata[`FTLV_LV_CONSTV_BIT]; // see [R5]
		end
		if (wr_timer)
			nxt_cur.timer_code = i_reg_wdata; // see [R9]
		nxt_cur.out_on = new_out_on;
		nxt_cur.mode = new_mode;
		if (i_fault_clr)
			nxt_cur.fault = 1'b0;
		case (cur_ff.state)
			FTLV_ST_IDLE:
			begin
				if (out_on_rise && (new_mode == FTLV_MODE_FLASH) && !cur_ff.const_v)
				begin
					if (low_at_start)
					begin
						nxt_cur.fault = 1'b1; // see [R1]
						nxt_cur.reduced = !cur_ff.lv_shdn; // see [R1]
						nxt_cur.state = cur_ff.lv_shdn ? FTLV_ST_BLOCKED : FTLV_ST_FLASH; // see [R2]
					end
					else
					begin
						nxt_cur.reduced = 1'b0;
						nxt_cur.state = FTLV_ST_FLASH;
					end
				end
			end
			FTLV_ST_FLASH:
			begin
				if (tmr_done)
				begin
					nxt_cur.out_on = 1'b0; // see [R11]
					nxt_cur.mode = FTLV_MODE_OFF; // see [R11]
					nxt_cur.state = FTLV_ST_IDLE;
					nxt_cur.reduced = 1'b0;
				end
				else if (!new_out_on || (new_mode != FTLV_MODE_FLASH))
				begin
					nxt_cur.state = FTLV_ST_IDLE;
					nxt_cur.reduced = 1'b0;
				end
			end
			FTLV_ST_BLOCKED:
			begin
				if (!new_out_on)
					nxt_cur.state = FTLV_ST_IDLE; // see [R2]
			end
			default:
			begin
				nxt_cur.state = FTLV_ST_IDLE;
			end
		endcase
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				`FTLV_ADDR_LV_CFG:
					nxt_cur.rdata = {cur_ff.const_v, cur_ff.lv_shdn, cur_ff.lv_start,
						cur_ff.lv_run};
				`FTLV_ADDR_TIMER:
					nxt_cur.rdata = cur_ff.timer_code;
				`FTLV_ADDR_CTRL:
					nxt_cur.rdata = {4'h0, cur_ff.out_on, 1'b0, cur_ff.mode};
				default:
					nxt_cur.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cur_ff <= '0;
			cur_ff.lv_run <= `FTLV_RST_LV_RUN;
			cur_ff.lv_start <= `FTLV_RST_LV_START; // see [R10]
			cur_ff.timer_code <= `FTLV_RST_TIMER; // see [R9]
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	// -----------------------------------------------------------------------
	// Outputs.
	// -----------------------------------------------------------------------
	assign o_reg_rdata = cur_ff.rdata;
	assign o_start_thresh = cur_ff.lv_start;
	assign o_run_thresh = cur_ff.lv_run;
	assign o_fault_uvlo = cur_ff.fault;
	// Constant-voltage mode replaces LED drive; otherwise the mode field rules. see [R4] [R5]
	assign o_mode = cur_ff.const_v ? FTLV_MODE_OFF : cur_ff.mode;
	assign o_const_v_boost_outputs = cur_ff.const_v; // see [R5]
	assign o_sink_enable = cur_ff.out_on && !cur_ff.const_v
		&& (cur_ff.state != FTLV_ST_BLOCKED); // see [R2]
	assign o_reduced_current = cur_ff.reduced && (cur_ff.state == FTLV_ST_FLASH); // see [R1]
	assign o_flash_active = (cur_ff.state == FTLV_ST_FLASH) && tmr_busy;

endmodule

`default_nettype wire

// *** core/ftlv_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing constants of the
 * flash timeout and low-voltage configuration block.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef FTLV_REGS_SVH
`define FTLV_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------------------
`define FTLV_ADDR_LV_CFG 8'h04
`define FTLV_ADDR_TIMER 8'h05
`define FTLV_ADDR_CTRL 8'h06

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define FTLV_LV_RUN_LSB 0
`define FTLV_LV_RUN_MSB 2
`define FTLV_LV_START_LSB 3
`define FTLV_LV_START_MSB 5
`define FTLV_LV_SHDN_BIT 6
`define FTLV_LV_CONSTV_BIT 7
`define FTLV_CTRL_MODE_LSB 0
`define FTLV_CTRL_MODE_MSB 1
`define FTLV_CTRL_OUTON_BIT 3

// ---------------------------------------------------------------------------
// Reset values and the threshold-off code.
// ---------------------------------------------------------------------------
`define FTLV_RST_LV_RUN 3'h4
`define FTLV_RST_LV_START 3'h5
`define FTLV_RST_TIMER 8'h23
`define FTLV_THRESH_OFF 3'h0

// ---------------------------------------------------------------------------
// Timing.
// ---------------------------------------------------------------------------
`define FTLV_CLK_HZ 10000000
`define FTLV_MS_PER_S 1000
`define FTLV_CYC_PER_MS (`FTLV_CLK_HZ / `FTLV_MS_PER_S)
`define FTLV_SLOPE_BREAK 8'h80
`define FTLV_FINE_STEP_MS 2
`define FTLV_COARSE_BASE_CODE 127
`define FTLV_COARSE_STEP_MS 8
`define FTLV_COARSE_BASE_MS 256

`endif

// *** core/ftlv_pkg.sv ***
/*
 * Types shared by the flash timeout and low-voltage configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ftlv_pkg;

	typedef enum logic [1:0]
	{
		FTLV_MODE_OFF = 2'b00,
		FTLV_MODE_IND = 2'b01,
		FTLV_MODE_ASSIST = 2'b10,
		FTLV_MODE_FLASH = 2'b11
	} ftlv_mode_e;

	typedef enum logic [1:0]
	{
		FTLV_ST_IDLE = 2'b00,
		FTLV_ST_FLASH = 2'b01,
		FTLV_ST_BLOCKED = 2'b10
	} ftlv_state_e;

	typedef logic [10:0] ftlv_ms_t;

endpackage

`default_nettype wire

// *** core/ftlv_timer.sv ***
/*
 * Flash duration timer: converts the eight-bit code to milliseconds and
 * pulses o_done once that time has passed after i_start.
 * Assumes one clock and a start pulse only while the timer is idle or to restart it.
 */
`include "ftlv_regs.svh"
`default_nettype none

module ftlv_timer #(
	parameter int CYC_PER_MS = `FTLV_CYC_PER_MS
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Control.
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic [7:0] i_code,
	// Status.
	output logic o_busy,
	output logic o_done
);
	import ftlv_pkg::*;

	typedef struct packed
	{
		logic busy;
		logic done;
		logic [15:0] div;
		ftlv_ms_t ms_left;
	} ftlv_tmr_s;

	ftlv_tmr_s cur_ff;
	ftlv_tmr_s nxt_cur;
	ftlv_ms_t dur_ms;
	logic ms_tick;

	// -----------------------------------------------------------------------
	// Two-slope code to milliseconds.
	// -----------------------------------------------------------------------
	always_comb
	begin
		if (i_code < `FTLV_SLOPE_BREAK)
			dur_ms = 11'((i_code + 11'd1) * `FTLV_FINE_STEP_MS); // see [R7]
		else
			dur_ms = 11'((i_code - `FTLV_COARSE_BASE_CODE) * `FTLV_COARSE_STEP_MS
				+ `FTLV_COARSE_BASE_MS); // see [R8]
	end

	assign ms_tick = (cur_ff.div == 16'(CYC_PER_MS - 1));

	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		if (i_start)
		begin
			nxt_cur.busy = 1'b1; // see [R12]
			nxt_cur.div = 16'h0000;
			nxt_cur.ms_left = dur_ms;
		end
		else if (i_stop)
		begin
			nxt_cur.busy = 1'b0;
		end
		else if (cur_ff.busy)
		begin
			nxt_cur.div = ms_tick ? 16'h0000 : 16'(cur_ff.div + 16'h0001);
			if (ms_tick)
			begin
				nxt_cur.ms_left = 11'(cur_ff.ms_left - 11'h001);
				if (cur_ff.ms_left == 11'h001)
				begin
					nxt_cur.busy = 1'b0; // see [R12]
					nxt_cur.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign o_busy = cur_ff.busy;
	assign o_done = cur_ff.done;

endmodule

`default_nettype wire

// *** bench/ftlv_host.sv ***
/* Host model: single-byte register reads and writes on the decoded bus.
 * Assumes the bench calls its tasks and the design samples on rising edges. */
`default_nettype none
module ftlv_host (
	// Clock and read data.
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	// Bus request.
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// Released lines show the inverse so stale data never looks valid.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge i_clk);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		q = i_rdata;
	endtask
	task automatic set_const_v(input logic [7:0] cfg);
		logic [7:0] q;
		acc(1'b1, 8'h06, 8'h00, q);
		acc(1'b1, 8'h04, {1'b1, cfg[6:0]}, q);
	endtask
endmodule
`default_nettype wire

// *** bench/ftlv_top_chk.sv ***
/* Concurrent checks on the ports of ftlv_top.
 * Assumes one clock domain and the bind at the foot of this file. */
`default_nettype none
module ftlv_top_chk
	import ftlv_pkg::*;
(
	// Design ports.
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_vin_below_start,
	input wire logic i_fault_clr,
	input wire logic [2:0] o_start_thresh,
	input wire logic o_fault_uvlo,
	input wire ftlv_pkg::ftlv_mode_e o_mode,
	input wire logic o_sink_enable,
	input wire logic o_reduced_current,
	input wire logic o_const_v_boost_outputs,
	input wire logic o_flash_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic go;
	assign go = i_reg_wr && i_reg_addr == 8'h06 && i_reg_wdata[3:0] == 4'hb &&
		!o_sink_enable && !o_flash_active && !o_const_v_boost_outputs;
	chk_low_fault: assert property (go && i_vin_below_start && o_start_thresh != 3'h0
		|=> o_fault_uvlo && o_sink_enable == o_reduced_current) else $error("low fault");
	chk_flash_start: assert property (go && (!i_vin_below_start || o_start_thresh == 3'h0)
		|=> o_flash_active && o_sink_enable && o_mode == FTLV_MODE_FLASH) else $error("start");
	// The timer's done pulse clears the enable and mode one edge after o_flash_active falls.
	chk_flash_end: assert property ($fell(o_flash_active) && !$past(i_reg_wr)
		|=> o_mode == FTLV_MODE_OFF && !o_sink_enable) else $error("flash end");
	chk_constv_off: assert property (o_const_v_boost_outputs
		|-> o_mode == FTLV_MODE_OFF && !o_sink_enable) else $error("const v");
	chk_unmapped_read: assert property (i_reg_rd && !(i_reg_addr inside {[8'h04:8'h06]})
		|=> o_reg_rdata == 8'h00) else $error("unmapped");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("rdata hold");
	chk_timer_rw: assert property (i_reg_wr && i_reg_addr == 8'h05 ##2 i_reg_rd &&
		i_reg_addr == 8'h05 |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("timer");
	chk_fault_sticky: assert property (o_fault_uvlo && !i_fault_clr |=> o_fault_uvlo)
		else $error("sticky");
	chk_fault_clear: assert property (i_fault_clr && !i_reg_wr |=> !o_fault_uvlo)
		else $error("clear");
	cover property (go && i_vin_below_start);
	cover property ($fell(o_flash_active) && !$past(i_reg_wr));
	cover property ($rose(o_const_v_boost_outputs));
endmodule
bind ftlv_top ftlv_top_chk ftlv_top_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_vin_below_start(i_vin_below_start),
	.i_fault_clr(i_fault_clr), .o_start_thresh(o_start_thresh), .o_fault_uvlo(o_fault_uvlo),
	.o_mode(o_mode), .o_sink_enable(o_sink_enable), .o_reduced_current(o_reduced_current),
	.o_const_v_boost_outputs(o_const_v_boost_outputs), .o_flash_active(o_flash_active));
`default_nettype wire

// *** bench/test_flash_timeout_low_voltage_config.sv ***
/* Self-checking bench for ftlv_top driven through the host model.
 * Assumes a shortened millisecond tick of 10 clocks. */
`default_nettype none
`define CHK(nm, ex, got) \
	begin compares++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module test_flash_timeout_low_voltage_config;
	import ftlv_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPM = 10;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_vin_below_start = 1'b0;
	logic i_fault_clr = 1'b0;
	logic [7:0] addr, wdata, rdata, q;
	logic wr, rd, fault, sink, reduced, boost, flash;
	logic [2:0] st, rt;
	ftlv_mode_e mode;
	int err_total = 0;
	int compares = 0;
	int n, ms;
	logic [7:0] codes [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	ftlv_top #(.CYC_PER_MS(CPM)) ftlv_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_vin_below_start(i_vin_below_start),
		.i_fault_clr(i_fault_clr), .o_start_thresh(st), .o_run_thresh(rt),
		.o_fault_uvlo(fault), .o_mode(mode), .o_sink_enable(sink),
		.o_reduced_current(reduced), .o_const_v_boost_outputs(boost), .o_flash_active(flash));
	ftlv_host ftlv_host_i (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	always #50 i_clk = ~i_clk;
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		ftlv_host_i.acc(1'b1, a, d, q);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] ex);
		ftlv_host_i.acc(1'b0, a, 8'h00, q);
		`CHK("rdata", ex, q)
	endtask
	task automatic clr;
		w(8'h06, 8'h00);
		i_fault_clr = 1'b1;
		@(negedge i_clk);
		i_fault_clr = 1'b0;
		`CHK("fault", 1'b0, fault)
	endtask
	task automatic end_of_test;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#5000000;
		err_total++;
		end_of_test();
	end
	initial
	begin
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_rst_b = 1'b1;
		r(8'h04, 8'h2c);
		r(8'h05, 8'h23);
		r(8'h06, 8'h00);
		r(8'h07, 8'h00);
		`CHK("thresh", 6'h2c, {st, rt})
		w(8'h05, 8'h80);
		r(8'h05, 8'h80);
		for (int i = 0; i < 4; i++)
		begin
			ms = (codes[i] < 8'h80) ? (codes[i] + 1) * 2 : (codes[i] - 127) * 8 + 256;
			w(8'h05, codes[i]);
			w(8'h06, 8'h0b);
			n = 0;
			while (flash === 1'b1 && n < 20000)
			begin
				@(negedge i_clk);
				n++;
			end
			`CHK("duration", 1'b1, n >= ms * CPM - 1 && n <= ms * CPM + 1)
			r(8'h06, 8'h00);
		end
		i_vin_below_start = 1'b1;
		w(8'h06, 8'h0b);
		`CHK("reduced", 2'b11, {reduced, fault})
		clr();
		w(8'h04, 8'h6c);
		w(8'h06, 8'h0b);
		`CHK("blocked", 3'b001, {sink, flash, fault})
		clr();
		w(8'h04, 8'h04);
		`CHK("thresh", 6'h04, {st, rt})
		w(8'h06, 8'h0b);
		`CHK("no check", 2'b10, {flash, fault})
		w(8'h06, 8'h00);
		i_vin_below_start = 1'b0;
		ftlv_host_i.set_const_v(8'h2c);
		`CHK("const v", 1'b1, boost)
		r(8'h04, 8'hac);
		w(8'h04, 8'h2c);
		w(8'h06, 8'h09);
		`CHK("normal", {FTLV_MODE_IND, 2'b10}, {mode, sink, boost})
		end_of_test();
	end
endmodule
`default_nettype wire
